// [ccf_engine.sv]
`default_nettype none
module ccf_engine #(
  // Pointer to the builtin metric array, as held at METRIC_PTR_ADDR.
  parameter logic [19:0] METRIC_BASE = 20'h00000
) (
  // Clock and reset.
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // Register port.
  input wire logic [15:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  // Decoder error report from the image and stream units.
  input wire logic decode_fault_in,
  // Engine status.
  output logic ring_drained_interrupt_out,
  output logic fault_out,
  output logic idle_out
);

  typedef struct packed {
    logic [11:0] wr_off;
    logic [11:0] rd_off;
    logic [11:0] fetch;
    logic [11:0] list_write_pointer;
    logic engine_hold_reset;
    ccf_pkg::ccf_state_t state;
    logic [29:0] skip;
    logic [4:0] font_slot;
    logic [14:0][19:0] font_ptr;
    logic [4:0] q_handle;
    logic [6:0] q_char;
    logic [15:0] font_height;
    logic [15:0] wid_w;
    logic [15:0] wid_h;
    logic [31:0] rdata;
    logic drained;
  } ccf_regs_t;

  ccf_regs_t s;
  ccf_regs_t next_s;
  // The reset flops sit outside the record: they run on the raw reset.
  logic rst_meta;
  logic rst_sync;
  logic rst_n;

  // Memories sit outside the state record: they carry no reset.
  logic [31:0] ring_mem [0:ccf_pkg::RING_WORDS-1];
  logic [31:0] list_memory [0:ccf_pkg::LIST_WORDS-1];

  logic [31:0] word;
  logic avail;
  logic consume;
  logic done;
  logic go_fault;
  logic [11:0] fetch_inc;
  logic list_we;
  logic [10:0] list_waddr;
  logic [31:0] list_wdata;
  logic host_list_we;
  logic ring_we;
  logic [19:0] metric_ptr;
  logic char_ok;
  logic [17:0] height_x3;
  logic [31:0] cnt_round;

  // Reset is released through two flops; only their output is used.
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end
  assign rst_n = rst_sync;

  // Current ring word; the index drops the byte bits of the offset.
  assign word = ring_mem[s.fetch[11:2]];
  assign avail = (s.fetch != s.wr_off);
  assign fetch_inc = s.fetch + ccf_pkg::RING_STEP;

  // Font metric lookup for the queried handle and character.
  always_comb begin
    metric_ptr = 20'h00000;
    char_ok = 1'b0;
    if (s.q_handle >= ccf_pkg::HANDLE_BUILTIN) begin
      metric_ptr = METRIC_BASE + ccf_pkg::METRIC_BLOCK_BYTES *
        {15'h0000, s.q_handle - ccf_pkg::HANDLE_BUILTIN};
      char_ok = (s.q_char >= ccf_pkg::CHAR_BUILTIN_MIN);
    end else if (s.q_handle != ccf_pkg::HANDLE_RESERVED) begin
      metric_ptr = s.font_ptr[s.q_handle[3:0]];
      char_ok = (s.q_char >= ccf_pkg::CHAR_USER_MIN);
    end
  end

  // Radius is height * 3 / 16, truncated.
  assign height_x3 = {2'b00, s.font_height} + {1'b0, s.font_height, 1'b0};

  // Bus side and command engine in one next-state process.
  always_comb begin
    next_s = s;
    next_s.drained = 1'b0;
    next_s.rdata = 32'h00000000;
    consume = 1'b0;
    done = 1'b0;
    go_fault = 1'b0;
    list_we = 1'b0;
    list_waddr = s.list_write_pointer[10:0];
    list_wdata = word;
    ring_we = 1'b0;
    host_list_we = 1'b0;
    cnt_round = word + 32'h00000003;

    // Register writes.
    if (wr_in) begin
      if (addr_in[15:12] == ccf_pkg::RING_WIN) begin
        ring_we = 1'b1;
      end else if (addr_in[15:13] == ccf_pkg::LIST_WIN) begin
        host_list_we = 1'b1;
      end else begin
        case (addr_in)
          ccf_pkg::REG_RING_WRITE: begin
            next_s.wr_off = wdata_in[11:0];
          end
          ccf_pkg::REG_RING_READ: begin
            // The read offset is the engine's own except while held.
            if (s.engine_hold_reset) begin
              next_s.rd_off = wdata_in[11:0];
            end
          end
          ccf_pkg::REG_HOLD_RESET: begin
            next_s.engine_hold_reset = wdata_in[0];
          end
          ccf_pkg::REG_FONT_QUERY: begin
            next_s.q_handle = wdata_in[4:0];
            next_s.q_char = wdata_in[14:8];
          end
          ccf_pkg::REG_RADIUS: begin
            next_s.font_height = wdata_in[15:0];
          end
          ccf_pkg::REG_WIDGET_DIM: begin
            next_s.wid_w = wdata_in[15:0];
            next_s.wid_h = wdata_in[31:16];
          end
          default: begin
          end
        endcase
      end
    end

    // Register reads; unmapped addresses answer zero.
    if (rd_in) begin
      if (addr_in[15:12] == ccf_pkg::RING_WIN) begin
        next_s.rdata = ring_mem[addr_in[11:2]];
      end else if (addr_in[15:13] == ccf_pkg::LIST_WIN) begin
        next_s.rdata = list_memory[addr_in[12:2]];
      end else begin
        case (addr_in)
          ccf_pkg::REG_RING_WRITE: next_s.rdata = {20'h00000, s.wr_off};
          ccf_pkg::REG_RING_READ: next_s.rdata = {20'h00000, s.rd_off};
          ccf_pkg::REG_LIST_PTR: begin
            next_s.rdata = {20'h00000, s.list_write_pointer};
          end
          ccf_pkg::REG_HOLD_RESET: begin
            next_s.rdata = {31'h00000000, s.engine_hold_reset};
          end
          ccf_pkg::REG_STATUS: begin
            next_s.rdata[ccf_pkg::ST_IDLE_BIT] = idle_out;
            next_s.rdata[ccf_pkg::ST_FAULT_BIT] = fault_out;
            next_s.rdata[ccf_pkg::ST_CHAR_OK_BIT] = char_ok;
            next_s.rdata[ccf_pkg::ST_VERTICAL_BIT] =
              (s.wid_w == s.wid_h);
          end
          ccf_pkg::REG_FONT_QUERY: begin
            next_s.rdata = {12'h000, metric_ptr};
          end
          ccf_pkg::REG_FONT_HEIGHT_ADDR: begin
            next_s.rdata = {12'h000,
              metric_ptr + ccf_pkg::METRIC_HEIGHT_OFS};
          end
          ccf_pkg::REG_RADIUS: begin
            next_s.rdata = {18'h00000, height_x3[17:4]};
          end
          ccf_pkg::REG_SHADE: begin
            next_s.rdata = {16'h0000, ccf_pkg::SHADE_SHADOW,
              ccf_pkg::SHADE_HIGHLIGHT};
          end
          default: next_s.rdata = 32'h00000000;
        endcase
      end
    end

    // Command engine; hold reset parks it and tracks the read offset.
    if (s.engine_hold_reset) begin
      next_s.state = ccf_pkg::CCF_IDLE;
      next_s.fetch = next_s.rd_off;
    end else begin
      case (s.state)
        ccf_pkg::CCF_IDLE: begin
          if (s.wr_off[1:0] != 2'b00 || s.rd_off[1:0] != 2'b00) begin
            go_fault = 1'b1;
          end else if (avail) begin
            if (word[31:24] != ccf_pkg::CMD_PREFIX) begin
              if (s.list_write_pointer == ccf_pkg::LIST_LIMIT) begin
                go_fault = 1'b1;
              end else begin
                list_we = 1'b1;
                next_s.list_write_pointer =
                  s.list_write_pointer + 12'h001;
                consume = 1'b1;
                done = 1'b1;
              end
            end else if (word == ccf_pkg::CMD_LIST_START) begin
              next_s.list_write_pointer = ccf_pkg::LIST_PTR_RST;
              consume = 1'b1;
              done = 1'b1;
            end else if (word == ccf_pkg::CMD_DECOMPRESS ||
                         word == ccf_pkg::CMD_IMAGE_DECODE) begin
              consume = 1'b1;
              next_s.state = ccf_pkg::CCF_COUNT;
            end else if (word == ccf_pkg::CMD_FONT_REGISTER) begin
              consume = 1'b1;
              next_s.state = ccf_pkg::CCF_FHANDLE;
            end else begin
              // Swap and unknown commands take one word and emit nothing.
              consume = 1'b1;
              done = 1'b1;
            end
          end
        end
        ccf_pkg::CCF_COUNT: begin
          if (decode_fault_in) begin
            go_fault = 1'b1;
          end else if (avail) begin
            // Byte count rounds up so padding bytes are skipped.
            next_s.skip = cnt_round[31:2];
            consume = 1'b1;
            if (cnt_round[31:2] == 30'h00000000) begin
              done = 1'b1;
              next_s.state = ccf_pkg::CCF_IDLE;
            end else begin
              next_s.state = ccf_pkg::CCF_SKIP;
            end
          end
        end
        ccf_pkg::CCF_SKIP: begin
          if (decode_fault_in) begin
            go_fault = 1'b1;
          end else if (avail) begin
            consume = 1'b1;
            next_s.skip = s.skip - 30'h00000001;
            if (s.skip == 30'h00000001) begin
              done = 1'b1;
              next_s.state = ccf_pkg::CCF_IDLE;
            end
          end
        end
        ccf_pkg::CCF_FHANDLE: begin
          if (avail) begin
            next_s.font_slot = word[4:0];
            consume = 1'b1;
            next_s.state = ccf_pkg::CCF_FPTR;
          end
        end
        ccf_pkg::CCF_FPTR: begin
          if (avail) begin
            // Only user handles 0-14 may be bound.
            if (s.font_slot < ccf_pkg::HANDLE_RESERVED) begin
              next_s.font_ptr[s.font_slot[3:0]] = word[19:0];
            end
            consume = 1'b1;
            done = 1'b1;
            next_s.state = ccf_pkg::CCF_IDLE;
          end
        end
        ccf_pkg::CCF_FAULT: begin
          // Refuses all commands until hold reset.
          next_s.state = ccf_pkg::CCF_FAULT;
        end
        default: begin
          next_s.state = ccf_pkg::CCF_IDLE;
        end
      endcase

      if (consume) begin
        next_s.fetch = fetch_inc;
      end
      // Read offset moves only once a whole command has finished, or to FAULT_OFFSET on a fault.
      if (done) begin
        next_s.rd_off = fetch_inc;
        next_s.drained = (fetch_inc == s.wr_off);
      end
      if (go_fault) begin
        next_s.state = ccf_pkg::CCF_FAULT;
        next_s.rd_off = ccf_pkg::FAULT_OFFSET;
        next_s.drained = 1'b1;
      end
    end
  end

  // Engine list writes take priority over host direct writes.
  always_ff @(posedge clk_sys_in) begin
    if (ring_we) begin
      ring_mem[addr_in[11:2]] <= wdata_in;
    end
    if (list_we) begin
      list_memory[list_waddr] <= list_wdata;
    end else if (host_list_we) begin
      list_memory[addr_in[12:2]] <= wdata_in;
    end
  end

  // State register on the synchronised reset.
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      s.wr_off <= ccf_pkg::OFFSET_RST;
      s.rd_off <= ccf_pkg::OFFSET_RST;
      s.fetch <= ccf_pkg::OFFSET_RST;
      s.list_write_pointer <= ccf_pkg::LIST_PTR_RST;
      s.engine_hold_reset <= 1'b0;
      s.state <= ccf_pkg::CCF_IDLE;
      s.skip <= 30'h00000000;
      s.font_slot <= 5'h00;
      s.font_ptr <= '0;
      s.q_handle <= 5'h00;
      s.q_char <= 7'h00;
      s.font_height <= 16'h0000;
      s.wid_w <= 16'h0000;
      s.wid_h <= 16'h0000;
      s.rdata <= 32'h00000000;
      s.drained <= 1'b0;
    end else begin
      s.wr_off <= next_s.wr_off;
      s.rd_off <= next_s.rd_off;
      s.fetch <= next_s.fetch;
      s.list_write_pointer <= next_s.list_write_pointer;
      s.engine_hold_reset <= next_s.engine_hold_reset;
      s.state <= next_s.state;
      s.skip <= next_s.skip;
      s.font_slot <= next_s.font_slot;
      s.font_ptr <= next_s.font_ptr;
      s.q_handle <= next_s.q_handle;
      s.q_char <= next_s.q_char;
      s.font_height <= next_s.font_height;
      s.wid_w <= next_s.wid_w;
      s.wid_h <= next_s.wid_h;
      s.rdata <= next_s.rdata;
      s.drained <= next_s.drained;
    end
  end

  // Outputs.
  assign rdata_out = s.rdata;
  assign ring_drained_interrupt_out = s.drained;
  assign fault_out = (s.state == ccf_pkg::CCF_FAULT);
  assign idle_out = (s.state == ccf_pkg::CCF_IDLE) &&
    (s.rd_off == s.wr_off);

endmodule
`default_nettype wire

// [ccf_pkg.sv]
`default_nettype none
package ccf_pkg;
  // Ring geometry: 4 KB of 32-bit entries, byte offsets 12 bits wide.
  localparam int RING_BYTES = 4096;
  localparam int RING_WORDS = RING_BYTES / 4;
  localparam logic [11:0] RING_STEP = 12'h004;
  localparam logic [11:0] FAULT_OFFSET = 12'hFFF;
  localparam logic [11:0] OFFSET_RST = 12'h000;
  // The list holds at most 2048 words; one more write is a fault.
  localparam int LIST_WORDS = 2048;
  localparam logic [11:0] LIST_LIMIT = 12'h800;
  localparam logic [11:0] LIST_PTR_RST = 12'h000;
  // Register byte offsets.
  localparam logic [15:0] REG_RING_WRITE = 16'h0000;
  localparam logic [15:0] REG_RING_READ = 16'h0004;
  localparam logic [15:0] REG_LIST_PTR = 16'h0008;
  localparam logic [15:0] REG_HOLD_RESET = 16'h000C;
  localparam logic [15:0] REG_STATUS = 16'h0010;
  localparam logic [15:0] REG_FONT_QUERY = 16'h0014;
  localparam logic [15:0] REG_FONT_HEIGHT_ADDR = 16'h0018;
  localparam logic [15:0] REG_RADIUS = 16'h001C;
  localparam logic [15:0] REG_WIDGET_DIM = 16'h0020;
  localparam logic [15:0] REG_SHADE = 16'h0024;
  // Memory windows: ring at 0x1000-0x1FFF, list at 0x2000-0x3FFF.
  localparam logic [3:0] RING_WIN = 4'h1;
  localparam logic [2:0] LIST_WIN = 3'b001;
  // Status bit positions.
  localparam int ST_IDLE_BIT = 0;
  localparam int ST_FAULT_BIT = 1;
  localparam int ST_CHAR_OK_BIT = 2;
  localparam int ST_VERTICAL_BIT = 3;
  // Command words.
  localparam logic [7:0] CMD_PREFIX = 8'hFF;
  localparam logic [31:0] CMD_LIST_START = 32'hFFFFFF00;
  localparam logic [31:0] CMD_LIST_SWAP = 32'hFFFFFF01;
  localparam logic [31:0] CMD_DECOMPRESS = 32'hFFFFFF22;
  localparam logic [31:0] CMD_IMAGE_DECODE = 32'hFFFFFF24;
  localparam logic [31:0] CMD_FONT_REGISTER = 32'hFFFFFF2B;
  // Font handles and characters.
  localparam logic [4:0] HANDLE_RESERVED = 5'h0F;
  localparam logic [4:0] HANDLE_BUILTIN = 5'h10;
  localparam logic [6:0] CHAR_BUILTIN_MIN = 7'h20;
  localparam logic [6:0] CHAR_USER_MIN = 7'h01;
  // Font metric block layout in bytes.
  localparam logic [19:0] METRIC_BLOCK_BYTES = 20'h00094;
  localparam logic [19:0] METRIC_FORMAT_OFS = 20'h00080;
  localparam logic [19:0] METRIC_STRIDE_OFS = 20'h00084;
  localparam logic [19:0] METRIC_WIDTH_OFS = 20'h00088;
  localparam logic [19:0] METRIC_HEIGHT_OFS = 20'h0008C;
  localparam logic [19:0] METRIC_GLYPH_OFS = 20'h00090;
  localparam logic [19:0] METRIC_PTR_ADDR = 20'hFFFFC;
  // Shading offsets in 1/16 pixel: highlight 0.5 px, shadow 1.0 px.
  localparam logic [7:0] SHADE_HIGHLIGHT = 8'h08;
  localparam logic [7:0] SHADE_SHADOW = 8'h10;
  // Engine states.
  typedef enum logic [2:0] {
    CCF_IDLE = 3'b000,
    CCF_COUNT = 3'b001,
    CCF_SKIP = 3'b010,
    CCF_FHANDLE = 3'b011,
    CCF_FPTR = 3'b100,
    CCF_FAULT = 3'b101
  } ccf_state_t;
endpackage
`default_nettype wire

// [ccf_checker.sv]
`default_nettype none
module ccf_checker (
  // Clock and reset.
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // Register port.
  input wire logic [15:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [31:0] rdata_out,
  // Decoder error and engine status.
  input wire logic decode_fault_in,
  input wire logic ring_drained_interrupt_out,
  input wire logic fault_out,
  input wire logic idle_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);
  // Setting hold reset is the only way out of the fault state.
  sequence hold_set;
    wr_in && addr_in == ccf_pkg::REG_HOLD_RESET && wdata_in[0];
  endsequence
  sequence fault_gone;
    ##[1:2] !fault_out;
  endsequence
  // Read data is zero except in the cycle after a read strobe.
  rdata_zero_a: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
    else $error("read data seen without a read");
  fault_drain_a: assert property (
    $rose(fault_out) |-> ring_drained_interrupt_out)
    else $error("fault without drained pulse");
  fault_stays_a: assert property (
    fault_out && !wr_in && !$past(wr_in) |=> fault_out)
    else $error("fault left without hold reset");
  drain_pulse_a: assert property (
    ring_drained_interrupt_out |=> !ring_drained_interrupt_out)
    else $error("drained pulse longer than one cycle");
  drain_idle_a: assert property (
    ring_drained_interrupt_out && !fault_out && !$past(wr_in) |-> idle_out)
    else $error("drained pulse while ring not empty");
  fault_idle_a: assert property (fault_out |-> !idle_out)
    else $error("idle reported during fault");
  idle_decode_a: assert property (
    idle_out && decode_fault_in && !wr_in |=> !fault_out)
    else $error("decoder error faulted an idle engine");
  hold_clear_a: assert property (hold_set |-> fault_gone)
    else $error("hold reset did not clear fault");
endmodule
bind ccf_engine ccf_checker ccf_checker_inst (
  .clk_sys_in(clk_sys_in),
  .nrst_in(nrst_in),
  .addr_in(addr_in),
  .wdata_in(wdata_in),
  .wr_in(wr_in),
  .rd_in(rd_in),
  .rdata_out(rdata_out),
  .decode_fault_in(decode_fault_in),
  .ring_drained_interrupt_out(ring_drained_interrupt_out),
  .fault_out(fault_out),
  .idle_out(idle_out)
);
`default_nettype wire

// [ccf_host.sv]
`default_nettype none
module ccf_host (
  // Clock.
  input wire logic clk_sys_in,
  // Register port, driven as the host.
  output logic [15:0] addr_out,
  output logic [31:0] wdata_out,
  output logic wr_out,
  output logic rd_out,
  input wire logic [31:0] rdata_in,
  input wire logic idle_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Bus lines start quiet so nothing is requested during reset.
  initial begin
    addr_out = 16'h0000;
    wdata_out = 32'h00000000;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end
  // Released lines are inverted so stale values cannot pass for fresh ones.
  task automatic write_reg(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge clk_sys_in);
    wr_out <= 1'b0;
    addr_out <= ~a;
    wdata_out <= ~d;
  endtask
  task automatic read_reg(input logic [15:0] a, output logic [31:0] d);
    @(posedge clk_sys_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clk_sys_in);
    rd_out <= 1'b0;
    addr_out <= ~a;
    // Data stand only in this cycle; take them at its closing edge.
    @(posedge clk_sys_in);
    d = rdata_in;
  endtask
  // Ring words go through the ring window, one word per entry.
  task automatic put_word(input logic [9:0] idx, input logic [31:0] d);
    write_reg({4'h1, idx, 2'b00}, d);
  endtask
  // Callers never post a whole ring, so full never looks empty.
  task automatic post(input logic [9:0] idx);
    write_reg(ccf_pkg::REG_RING_WRITE, {20'h0, idx, 2'b00});
  endtask
  task automatic recover();
    write_reg(ccf_pkg::REG_HOLD_RESET, 32'h1);
    write_reg(ccf_pkg::REG_RING_READ, 32'h0);
    write_reg(ccf_pkg::REG_RING_WRITE, 32'h0);
    write_reg(ccf_pkg::REG_HOLD_RESET, 32'h0);
  endtask
  // The engine sees a new offset a cycle late, so idle is polled after that.
  task automatic wait_idle();
    repeat (2) @(posedge clk_sys_in);
    for (int i = 0; i < 200 && idle_in !== 1'b1; i++) begin
      @(posedge clk_sys_in);
    end
  endtask
endmodule
`default_nettype wire

// [test_coprocessor_command_fifo.sv]
`default_nettype none
`define CHK(what, exp, got) begin \
  check_count++; \
  if ((got) !== (exp)) begin \
    mismatches++; \
    $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); \
  end \
end
module test_coprocessor_command_fifo;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [19:0] MBASE = 20'h0A000;
  logic clk_sys_in = 1'b0;
  logic nrst_in;
  logic decode_fault_in;
  logic [15:0] addr_in;
  logic [31:0] wdata_in;
  logic wr_in;
  logic rd_in;
  logic [31:0] rdata_out;
  logic ring_drained_interrupt_out;
  logic fault_out;
  logic idle_out;
  int mismatches = 0;
  int check_count = 0;
  int drains = 0;
  int n;
  ccf_engine #(.METRIC_BASE(MBASE)) ccf_engine_inst (
    .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .decode_fault_in(decode_fault_in),
    .ring_drained_interrupt_out(ring_drained_interrupt_out),
    .fault_out(fault_out), .idle_out(idle_out));
  ccf_host ccf_host_inst (
    .clk_sys_in(clk_sys_in), .addr_out(addr_in), .wdata_out(wdata_in),
    .wr_out(wr_in), .rd_out(rd_in), .rdata_in(rdata_out),
    .idle_in(idle_out));
  // Free-running clock and a count of drained pulses.
  always #5 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) begin
    if (ring_drained_interrupt_out === 1'b1) drains++;
  end
  task automatic rchk(input string s, input logic [15:0] a,
                      input logic [31:0] e);
    logic [31:0] d;
    ccf_host_inst.read_reg(a, d);
    `CHK(s, e, d)
  endtask
  task automatic schk(input string s, input int b, input logic e);
    logic [31:0] d;
    ccf_host_inst.read_reg(ccf_pkg::REG_STATUS, d);
    `CHK(s, e, d[b])
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    ccf_host_inst.write_reg(a, d);
  endtask
  task automatic put(input logic [9:0] i, input logic [31:0] d);
    ccf_host_inst.put_word(i, d);
  endtask
  task automatic stop_test();
    $display("Checks made %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Plain words are copied in order and one pulse marks the empty ring.
  task automatic t_copy();
    n = drains;
    put(10'd0, 32'h02000001);
    put(10'd1, 32'h04FF0000);
    put(10'd2, 32'h22000003);
    ccf_host_inst.post(10'd3);
    ccf_host_inst.wait_idle();
    // A decoder error while idle must not fault the engine.
    decode_fault_in <= 1'b1;
    @(posedge clk_sys_in);
    decode_fault_in <= 1'b0;
    @(posedge clk_sys_in);
    `CHK("idle fault", 1'b0, fault_out)
    rchk("read offset", ccf_pkg::REG_RING_READ, 32'hC);
    rchk("list pointer", ccf_pkg::REG_LIST_PTR, 32'h3);
    rchk("list word", 16'h2008, 32'h22000003);
    `CHK("drained pulses", n + 1, drains)
    $display("t_copy done");
  endtask
  // Payload that mimics commands must be skipped, padding included.
  task automatic t_skip();
    put(10'd3, ccf_pkg::CMD_DECOMPRESS);
    put(10'd4, 32'h5);
    put(10'd5, ccf_pkg::CMD_LIST_START);
    put(10'd6, 32'h01234567);
    put(10'd7, ccf_pkg::CMD_LIST_START);
    put(10'd8, 32'h0A0B0C0D);
    put(10'd9, ccf_pkg::CMD_LIST_SWAP);
    put(10'd10, 32'hFFFFFF77);
    ccf_host_inst.post(10'd11);
    ccf_host_inst.wait_idle();
    rchk("list pointer", ccf_pkg::REG_LIST_PTR, 32'h1);
    rchk("list word", 16'h2000, 32'h0A0B0C0D);
    $display("t_skip done");
  endtask
  // Words placed at the ring's end and start run as one sequence.
  task automatic t_wrap();
    wr(ccf_pkg::REG_HOLD_RESET, 32'h1);
    wr(ccf_pkg::REG_RING_READ, 32'hFF8);
    wr(ccf_pkg::REG_RING_WRITE, 32'hFF8);
    wr(ccf_pkg::REG_HOLD_RESET, 32'h0);
    put(10'd1022, 32'h11000001);
    put(10'd1023, 32'h11000002);
    put(10'd0, 32'h11000003);
    ccf_host_inst.post(10'd1);
    ccf_host_inst.wait_idle();
    rchk("read offset", ccf_pkg::REG_RING_READ, 32'h4);
    rchk("list word", 16'h200C, 32'h11000003);
    $display("t_wrap done");
  endtask
  // Font metrics, character ranges and widget geometry.
  task automatic t_font();
    put(10'd1, ccf_pkg::CMD_FONT_REGISTER);
    put(10'd2, 32'h3);
    put(10'd3, 32'h00100);
    put(10'd4, ccf_pkg::CMD_FONT_REGISTER);
    put(10'd5, 32'hF);
    put(10'd6, 32'h00200);
    ccf_host_inst.post(10'd7);
    ccf_host_inst.wait_idle();
    wr(ccf_pkg::REG_FONT_QUERY, 32'h0000671F);
    rchk("metric ptr", ccf_pkg::REG_FONT_QUERY, 32'h0A8AC);
    rchk("height addr", ccf_pkg::REG_FONT_HEIGHT_ADDR, 32'h0A938);
    schk("char valid", ccf_pkg::ST_CHAR_OK_BIT, 1'b1);
    wr(ccf_pkg::REG_FONT_QUERY, 32'h00001F10);
    rchk("metric ptr", ccf_pkg::REG_FONT_QUERY, 32'h0A000);
    schk("char valid", ccf_pkg::ST_CHAR_OK_BIT, 1'b0);
    wr(ccf_pkg::REG_FONT_QUERY, 32'h0000200F);
    rchk("metric ptr", ccf_pkg::REG_FONT_QUERY, 32'h0);
    wr(ccf_pkg::REG_FONT_QUERY, 32'h00000103);
    rchk("metric ptr", ccf_pkg::REG_FONT_QUERY, 32'h00100);
    schk("char valid", ccf_pkg::ST_CHAR_OK_BIT, 1'b1);
    wr(ccf_pkg::REG_RADIUS, 32'h1B);
    rchk("radius", ccf_pkg::REG_RADIUS, 32'h5);
    rchk("shading", ccf_pkg::REG_SHADE, 32'h1008);
    wr(ccf_pkg::REG_WIDGET_DIM, 32'h00280028);
    schk("vertical", ccf_pkg::ST_VERTICAL_BIT, 1'b1);
    wr(ccf_pkg::REG_WIDGET_DIM, 32'h00290028);
    schk("vertical", ccf_pkg::ST_VERTICAL_BIT, 1'b0);
    $display("t_font done");
  endtask
  // A decoder error mid-payload faults and blocks later commands.
  task automatic t_fault();
    put(10'd7, ccf_pkg::CMD_IMAGE_DECODE);
    put(10'd8, 32'h8);
    ccf_host_inst.post(10'd9);
    repeat (4) @(posedge clk_sys_in);
    n = drains;
    decode_fault_in <= 1'b1;
    @(posedge clk_sys_in);
    decode_fault_in <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    `CHK("fault", 1'b1, fault_out)
    `CHK("drained pulses", n + 1, drains)
    rchk("read offset", ccf_pkg::REG_RING_READ, 32'hFFF);
    put(10'd9, 32'h33000000);
    ccf_host_inst.post(10'd10);
    repeat (4) @(posedge clk_sys_in);
    rchk("list pointer", ccf_pkg::REG_LIST_PTR, 32'h4);
    ccf_host_inst.recover();
    rchk("read offset", ccf_pkg::REG_RING_READ, 32'h0);
    schk("idle", ccf_pkg::ST_IDLE_BIT, 1'b1);
    $display("t_fault done");
  endtask
  // Exactly 2048 list words fit; the next one faults.
  task automatic t_overflow();
    for (int i = 0; i <= 2048; i++) begin
      put(i[9:0], (i == 0) ? ccf_pkg::CMD_LIST_START : {8'h01, i[23:0]});
      ccf_host_inst.post(i[9:0] + 10'd1);
    end
    ccf_host_inst.wait_idle();
    rchk("list pointer", ccf_pkg::REG_LIST_PTR, 32'h800);
    `CHK("fault", 1'b0, fault_out)
    put(10'd1, 32'h01FFFFFF);
    ccf_host_inst.post(10'd2);
    repeat (4) @(posedge clk_sys_in);
    `CHK("fault", 1'b1, fault_out)
    ccf_host_inst.recover();
    wr(ccf_pkg::REG_RING_WRITE, 32'h2);
    repeat (4) @(posedge clk_sys_in);
    `CHK("fault", 1'b1, fault_out)
    ccf_host_inst.recover();
    $display("t_overflow done");
  endtask
  // Reset, then the scenarios in order.
  initial begin
    nrst_in = 1'b0;
    decode_fault_in = 1'b0;
    repeat (4) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    `CHK("idle", 1'b1, idle_out)
    rchk("unmapped", 16'h0040, 32'h0);
    t_copy();
    t_skip();
    t_wrap();
    t_font();
    t_fault();
    t_overflow();
    stop_test();
  end
  // Watchdog sized well above the expected run length.
  initial begin
    repeat (40000) @(posedge clk_sys_in);
    mismatches++;
    $display("Watchdog expired");
    stop_test();
  end
endmodule
`default_nettype wire
